/* File: hdl/ccrc_top.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps

// Notes on behaviour
// - out of reset the loop is off and the input goes through the divider.
// - divider ratios 2 to 6 are chosen by a three-bit code.
// - the ratio code resets to divide-by-four.
// - in divider mode at least divide-by-two is applied.
// - writes wait in staging until 0x01 lands in the update register.
// - power code 01 means asynchronous power-down, and is the reset value.
// - power code 00 runs the loop normally.
// - route bit 0 clear feeds distribution from the divider.
// - route bit 1 clear picks the external clock input.
// - polarity bit clear is positive, set is negative.
// - loop on with external input keeps internal oscillator off.
// - power, ratio and routing return to defaults after reset.
// - route bit 0 set bypasses the divider.
// - route bit 1 set picks the internal oscillator.
module ccrc_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 ext_clk_in,
    input  wire logic                 int_osc_in,
    output ccrc_pkg::ccrc_pll_pwr_type pll_power_mode,
    output logic                      pll_power_down,
    output logic                      pll_enable,
    output logic                      pfd_polarity_negative,
    output logic                      int_osc_select,
    output logic                      int_osc_power_on,
    output logic                      ext_to_prescaler,
    output logic                      vco_div_bypass,
    output logic      [2:0]           vco_div_ratio,
    output logic                      dist_clk
);
    import ccrc_pkg::*;
`include "ccrc_consts.svh"

    // ======================================================
    // declarations
    ccrc_cfg_if cfg ();

    ccrc_apb_state_type state_reg;
    ccrc_reg_sel_type   sel;
    logic [31:0]        prdata_reg;
    logic               pslverr_reg;
    logic               setup;
    logic               access;
    logic               wr_ok;
    logic               bad_ratio;
    ccrc_pll_pwr_type   pwr_reg;
    logic               pll_pd_reg;
    logic               pll_en_reg;
    logic               pol_reg;
    logic               int_sel_reg;
    logic               int_pwr_reg;
    logic               ext_pre_reg;
    logic               byp_reg;
    logic [2:0]         ratio_reg;
    logic               pready_reg;

    // ======================================================
    // decode helpers
    function automatic ccrc_reg_sel_type dec_sel(
        input logic [11:0] a
    );
        if (a == `CCRC_ADDR_PLL) begin
            dec_sel = CCRC_SEL_PLL;
        end else if (a == `CCRC_ADDR_DIV) begin
            dec_sel = CCRC_SEL_DIV;
        end else if (a == `CCRC_ADDR_ROUTE) begin
            dec_sel = CCRC_SEL_ROUTE;
        end else if (a == `CCRC_ADDR_UPD) begin
            dec_sel = CCRC_SEL_UPD;
        end else if (a == `CCRC_ADDR_STAT) begin
            dec_sel = CCRC_SEL_STAT;
        end else begin
            dec_sel = CCRC_SEL_NONE;
        end
    endfunction

    function automatic logic [7:0] rd_val(
        input ccrc_reg_sel_type s
    );
        rd_val = 8'h00;
        unique case (s)
            CCRC_SEL_PLL: begin
                rd_val = cfg.stg_pll;
            end
            CCRC_SEL_DIV: begin
                rd_val = {5'h00, cfg.stg_div};
            end
            CCRC_SEL_ROUTE: begin
                rd_val = {6'h00, cfg.stg_route};
            end
            CCRC_SEL_STAT: begin
                rd_val = {cfg.act_pol, cfg.act_int, cfg.act_bypass,
                          cfg.act_div, cfg.act_pwr};
            end
            CCRC_SEL_UPD, CCRC_SEL_NONE: begin
                rd_val = 8'h00;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    endfunction

    // ======================================================
    // apb slave: one setup cycle, answer on first access cycle
    assign sel       = dec_sel(paddr);
    assign setup     = psel & ~penable;
    assign access    = psel & penable & (state_reg == CCRC_ST_READY);
    assign bad_ratio = (sel == CCRC_SEL_DIV) & pwrite &
                       (pwdata[`CCRC_DIV_MSB:0] > `CCRC_DIV_MAX_CODE);
    assign wr_ok     = access & pwrite & ~pslverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CCRC_ST_IDLE;
        end else begin
            unique case (state_reg)
                CCRC_ST_IDLE: begin
                    if (setup) begin
                        state_reg <= CCRC_ST_READY;
                    end
                end
                CCRC_ST_READY: begin
                    state_reg <= CCRC_ST_IDLE;
                end
                default: begin
                    state_reg <= CCRC_ST_IDLE;
                end
            endcase
        end
    end

    // read data and error are settled before the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= {24'h00_0000, rd_val(sel)};
            pslverr_reg <= (sel == CCRC_SEL_NONE) | bad_ratio;
        end
    end

    // own flop so the pin carries no state decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= (state_reg == CCRC_ST_IDLE) & setup;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ======================================================
    // write strobes into the staging registers
    assign cfg.wdata    = pwdata[7:0];
    assign cfg.wr_pll   = wr_ok & (sel == CCRC_SEL_PLL);
    assign cfg.wr_div   = wr_ok & (sel == CCRC_SEL_DIV);
    assign cfg.wr_route = wr_ok & (sel == CCRC_SEL_ROUTE);
    // only the exact key commits; stray values are dropped
    assign cfg.commit   = wr_ok & (sel == CCRC_SEL_UPD) &
                          (pwdata[7:0] == `CCRC_UPD_KEY);

    ccrc_stage u_stage (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg.stage)
    );

    ccrc_divider u_divider (
        .pclk       (pclk),
        .presetn    (presetn),
        .ext_clk_in (ext_clk_in),
        .int_osc_in (int_osc_in),
        .cfg        (cfg.div),
        .dist_clk   (dist_clk)
    );

    // ======================================================
    // control pins, registered from the active set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg    <= CCRC_PWR_ASYNC_PD;
            pll_pd_reg <= 1'b1;
            pll_en_reg <= 1'b0;
        end else begin
            pwr_reg    <= cfg.act_pwr;
            // reserved codes also keep the loop down
            pll_pd_reg <= (cfg.act_pwr != CCRC_PWR_ON);
            pll_en_reg <= (cfg.act_pwr == CCRC_PWR_ON);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_sel_reg <= 1'b0;
            int_pwr_reg <= 1'b0;
            ext_pre_reg <= 1'b0;
            byp_reg     <= 1'b0;
        end else begin
            int_sel_reg <= cfg.act_int;
            int_pwr_reg <= cfg.act_int;
            ext_pre_reg <= (cfg.act_pwr == CCRC_PWR_ON) &
                           ~cfg.act_int;
            byp_reg     <= cfg.act_bypass;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_reg   <= 1'b0;
            ratio_reg <= 3'(`CCRC_RST_DIV + `CCRC_DIV_BASE);
        end else begin
            pol_reg   <= cfg.act_pol;
            ratio_reg <= 3'(cfg.act_div + `CCRC_DIV_BASE);
        end
    end

    assign pll_power_mode        = pwr_reg;
    assign pll_power_down        = pll_pd_reg;
    assign pll_enable            = pll_en_reg;
    assign pfd_polarity_negative = pol_reg;
    assign int_osc_select        = int_sel_reg;
    assign int_osc_power_on      = int_pwr_reg;
    assign ext_to_prescaler      = ext_pre_reg;
    assign vco_div_bypass        = byp_reg;
    assign vco_div_ratio         = ratio_reg;

    // ======================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_upd_write;
        psel && penable && pready && pwrite && !pslverr &&
        paddr == `CCRC_ADDR_UPD && pwdata[7:0] == `CCRC_UPD_KEY;
    endsequence

    sequence s_div_bad_setup;
        psel && !penable && pwrite && paddr == `CCRC_ADDR_DIV &&
        pwdata[`CCRC_DIV_MSB:0] > `CCRC_DIV_MAX_CODE;
    endsequence

    property p_reset_defaults;
        $rose(presetn) |-> cfg.act_pwr == CCRC_PWR_ASYNC_PD &&
            cfg.act_div == `CCRC_RST_DIV && !cfg.act_bypass &&
            !cfg.act_int && pll_power_down && vco_div_ratio == 3'h4;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("defaults wrong after reset release");

    property p_commit;
        s_upd_write |=> cfg.act_div == $past(cfg.stg_div) &&
            cfg.act_bypass == $past(cfg.stg_route[`CCRC_BYP_BIT]) &&
            cfg.act_int == $past(cfg.stg_route[`CCRC_INT_BIT])
            ##1 vco_div_bypass == $past(cfg.stg_route[0], 2);
    endproperty
    a_commit: assert property (p_commit)
        else $error("update write did not move staged values");

    property p_hold;
        !cfg.commit |=> $stable(cfg.act_div) &&
            $stable(cfg.act_pwr) && $stable(cfg.act_int) &&
            $stable(cfg.act_bypass) && $stable(cfg.act_pol);
    endproperty
    a_hold: assert property (p_hold)
        else $error("active set changed without update");

    property p_pll_pd;
        cfg.act_pwr == CCRC_PWR_ASYNC_PD |=>
            pll_power_down && !pll_enable;
    endproperty
    a_pll_pd: assert property (p_pll_pd)
        else $error("loop not powered down for code 01");

    property p_pll_on;
        cfg.act_pwr == CCRC_PWR_ON |=> pll_enable && !pll_power_down;
    endproperty
    a_pll_on: assert property (p_pll_on)
        else $error("loop not running for code 00");

    property p_int_off;
        cfg.act_pwr == CCRC_PWR_ON && !cfg.act_int |=>
            ext_to_prescaler && !int_osc_power_on;
    endproperty
    a_int_off: assert property (p_int_off)
        else $error("internal oscillator on with external input");

    property p_bypass_ext;
        cfg.act_bypass && !cfg.act_int |=>
            dist_clk == $past(ext_clk_in);
    endproperty
    a_bypass_ext: assert property (p_bypass_ext)
        else $error("bypass does not pass external input");

    property p_bypass_int;
        cfg.act_bypass && cfg.act_int |=>
            dist_clk == $past(int_osc_in) && int_osc_select;
    endproperty
    a_bypass_int: assert property (p_bypass_int)
        else $error("bypass does not pass internal oscillator");

    property p_pol;
        cfg.act_pol != $past(cfg.act_pol) |=>
            pfd_polarity_negative == $past(cfg.act_pol);
    endproperty
    a_pol: assert property (p_pol)
        else $error("polarity pin does not follow field");

    property p_bad_ratio;
        s_div_bad_setup |=> pready && pslverr ##1 $stable(cfg.stg_div);
    endproperty
    a_bad_ratio: assert property (p_bad_ratio)
        else $error("illegal ratio code accepted");

    property p_ratio_range;
        vco_div_ratio >= 3'h2 && vco_div_ratio <= 3'h6;
    endproperty
    a_ratio_range: assert property (p_ratio_range)
        else $error("divider ratio out of range");

    property p_unmapped;
        psel && !penable && dec_sel(paddr) == CCRC_SEL_NONE |=>
            pready && pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address not refused");
endmodule // ccrc_top

/* File: include/ccrc_consts.svh */
`ifndef CCRC_CONSTS_SVH
`define CCRC_CONSTS_SVH

// ==========================================================
// register indices; byte address is four times the index
`define CCRC_IDX_PLL      10'h010
`define CCRC_IDX_DIV      10'h1E0
`define CCRC_IDX_ROUTE    10'h1E1
`define CCRC_IDX_UPD      10'h232
`define CCRC_IDX_STAT     10'h233
`define CCRC_ADDR_PLL     {`CCRC_IDX_PLL, 2'h0}
`define CCRC_ADDR_DIV     {`CCRC_IDX_DIV, 2'h0}
`define CCRC_ADDR_ROUTE   {`CCRC_IDX_ROUTE, 2'h0}
`define CCRC_ADDR_UPD     {`CCRC_IDX_UPD, 2'h0}
`define CCRC_ADDR_STAT    {`CCRC_IDX_STAT, 2'h0}

// ==========================================================
// field positions
`define CCRC_PWR_MSB      1
`define CCRC_PWR_LSB      0
`define CCRC_POL_BIT      7
`define CCRC_DIV_MSB      2
`define CCRC_BYP_BIT      0
`define CCRC_INT_BIT      1

// ==========================================================
// reset values and codes
`define CCRC_RST_PLL      8'h01
`define CCRC_RST_DIV      3'h2
`define CCRC_RST_ROUTE    2'h0
`define CCRC_UPD_KEY      8'h01
`define CCRC_DIV_MAX_CODE 3'h4
`define CCRC_DIV_BASE     3'h2

`endif

/* File: include/ccrc_pkg.sv */
package ccrc_pkg;

    // ======================================================
    // types
    typedef enum logic [1:0] {
        CCRC_PWR_ON       = 2'h0,
        CCRC_PWR_ASYNC_PD = 2'h1,
        CCRC_PWR_RSV2     = 2'h2,
        CCRC_PWR_RSV3     = 2'h3
    } ccrc_pll_pwr_type;

    typedef enum logic [2:0] {
        CCRC_SEL_NONE  = 3'h0,
        CCRC_SEL_PLL   = 3'h1,
        CCRC_SEL_DIV   = 3'h2,
        CCRC_SEL_ROUTE = 3'h3,
        CCRC_SEL_UPD   = 3'h4,
        CCRC_SEL_STAT  = 3'h5
    } ccrc_reg_sel_type;

    typedef enum logic [1:0] {
        CCRC_ST_IDLE  = 2'h0,
        CCRC_ST_READY = 2'h1
    } ccrc_apb_state_type;

endpackage

/* File: include/ccrc_cfg_if.sv */
`timescale 1ns/100ps
interface ccrc_cfg_if;
    import ccrc_pkg::*;
    logic             wr_pll;
    logic             wr_div;
    logic             wr_route;
    logic             commit;
    logic [7:0]       wdata;
    logic [7:0]       stg_pll;
    logic [2:0]       stg_div;
    logic [1:0]       stg_route;
    ccrc_pll_pwr_type act_pwr;
    logic             act_pol;
    logic [2:0]       act_div;
    logic             act_bypass;
    logic             act_int;

    modport stage (input wr_pll, wr_div, wr_route, commit, wdata,
                   output stg_pll, stg_div, stg_route, act_pwr,
                   act_pol, act_div, act_bypass, act_int);
    modport ctrl (output wr_pll, wr_div, wr_route, commit, wdata,
                  input stg_pll, stg_div, stg_route, act_pwr,
                  act_pol, act_div, act_bypass, act_int);
    modport div (input act_div, act_bypass, act_int);
endinterface

/* File: hdl/ccrc_stage.sv */
`timescale 1ns/100ps
module ccrc_stage (
    input wire logic pclk,
    input wire logic presetn,
    ccrc_cfg_if.stage cfg
);
    import ccrc_pkg::*;
`include "ccrc_consts.svh"

    // ======================================================
    // staging copies, written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.stg_pll   <= `CCRC_RST_PLL;
            cfg.stg_div   <= `CCRC_RST_DIV;
            cfg.stg_route <= `CCRC_RST_ROUTE;
        end else begin
            if (cfg.wr_pll) begin
                cfg.stg_pll <= cfg.wdata;
            end
            if (cfg.wr_div) begin
                cfg.stg_div <= cfg.wdata[`CCRC_DIV_MSB:0];
            end
            if (cfg.wr_route) begin
                cfg.stg_route <= cfg.wdata[`CCRC_INT_BIT:0];
            end
        end
    end

    // ======================================================
    // active set; all fields move together on commit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.act_pwr    <= ccrc_pll_pwr_type'(2'(`CCRC_RST_PLL));
            cfg.act_pol    <= 1'b0;
            cfg.act_div    <= `CCRC_RST_DIV;
            cfg.act_bypass <= 1'b0;
            cfg.act_int    <= 1'b0;
        end else if (cfg.commit) begin
            cfg.act_pwr    <= ccrc_pll_pwr_type'(
                cfg.stg_pll[`CCRC_PWR_MSB:`CCRC_PWR_LSB]);
            cfg.act_pol    <= cfg.stg_pll[`CCRC_POL_BIT];
            cfg.act_div    <= cfg.stg_div;
            cfg.act_bypass <= cfg.stg_route[`CCRC_BYP_BIT];
            cfg.act_int    <= cfg.stg_route[`CCRC_INT_BIT];
        end
    end
endmodule // ccrc_stage

/* File: hdl/ccrc_divider.sv */
`timescale 1ns/100ps
module ccrc_divider (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ext_clk_in,
    input  wire logic int_osc_in,
    ccrc_cfg_if.div   cfg,
    output logic      dist_clk
);
    import ccrc_pkg::*;
`include "ccrc_consts.svh"

    logic       src;
    logic       src_prev_reg;
    logic       rise;
    logic [2:0] ratio;
    logic [2:0] cnt_reg;
    logic       div_reg;
    logic       dist_reg;

    assign src   = cfg.act_int ? int_osc_in : ext_clk_in;
    assign rise  = src & ~src_prev_reg;
    assign ratio = 3'(cfg.act_div + `CCRC_DIV_BASE);

    // ======================================================
    // source edge counter; >= wrap copes with a ratio shrunk mid-count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_reg <= 1'b0;
            cnt_reg      <= 3'h0;
            div_reg      <= 1'b0;
        end else begin
            src_prev_reg <= src;
            if (rise) begin
                if (cnt_reg >= 3'(ratio - 3'h1)) begin
                    cnt_reg <= 3'h0;
                    div_reg <= 1'b1;
                end else begin
                    cnt_reg <= 3'(cnt_reg + 3'h1);
                    div_reg <= (3'(cnt_reg + 3'h1) < (ratio >> 1));
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dist_reg <= 1'b0;
        end else begin
            dist_reg <= cfg.act_bypass ? src : div_reg;
        end
    end

    assign dist_clk = dist_reg;

    property p_min_div;
        @(posedge pclk) disable iff (!presetn)
        (rise && !cfg.act_bypass && cnt_reg == 3'h0)
            |=> cnt_reg == 3'h1 && div_reg == ($past(ratio) > 3'h3);
    endproperty
    a_min_div: assert property (p_min_div)
        else $error("divider passed source edges undivided");
endmodule // ccrc_divider

/* File: test/ccrc_src_model.sv */
`timescale 1ns/100ps
module ccrc_src_model (
    input  wire logic pclk,
    input  wire logic slow,
    output logic      ext_clk_in,
    output logic      int_osc_in
);
    // ==========================================================
    // free-running sources
    // levels are sampled on pclk, so they step on pclk edges only
    logic [1:0] cnt;
    initial begin
        ext_clk_in = 1'b0;
        int_osc_in = 1'b0;
        cnt        = 2'h0;
    end
    always @(posedge pclk) begin
        cnt <= cnt + 2'h1;
        // slow mode keeps the source well below the divider limit
        if (!slow || cnt == 2'h0) begin
            ext_clk_in <= ~ext_clk_in;
        end
        int_osc_in <= cnt[0];
    end
endmodule // ccrc_src_model

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`include "ccrc_consts.svh"
module tb_top;
    import ccrc_pkg::*;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic             slow = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0;
    logic [31:0]      prdata;
    logic             pready, pslverr, ext_clk_in, int_osc_in, dist_clk;
    ccrc_pll_pwr_type pll_power_mode;
    logic             pll_power_down, pll_enable, pfd_polarity_negative;
    logic             int_osc_select, int_osc_power_on, ext_to_prescaler;
    logic             vco_div_bypass;
    logic [2:0]       vco_div_ratio;
    int               err_total = 0;
    int               samples_checked = 0;
    logic [8:0]       notes[$];

    always #5 pclk = ~pclk;

    ccrc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk_in(ext_clk_in),
        .int_osc_in(int_osc_in), .pll_power_mode(pll_power_mode),
        .pll_power_down(pll_power_down), .pll_enable(pll_enable),
        .pfd_polarity_negative(pfd_polarity_negative),
        .int_osc_select(int_osc_select),
        .int_osc_power_on(int_osc_power_on),
        .ext_to_prescaler(ext_to_prescaler),
        .vco_div_bypass(vco_div_bypass), .vco_div_ratio(vco_div_ratio),
        .dist_clk(dist_clk));
    ccrc_src_model src (.pclk(pclk), .slow(slow),
        .ext_clk_in(ext_clk_in), .int_osc_in(int_osc_in));

    // ==========================================================
    // reporting
    task close_out;
        $display("mismatches %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cmp_rd(input logic [8:0] g, input logic [8:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task cmp_per(input int g, input int e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // spacing of dist_clk rises; fast source rises every second edge
    task per_chk(input int e);
        int   n;
        int   t;
        int   w;
        logic p;
        n = 0;
        t = 0;
        w = 0;
        p = dist_clk;
        while (t < 2 && w < 200) begin
            @(posedge pclk);
            w++;
            if (t == 1) begin
                n++;
            end
            if (dist_clk === 1'b1 && p === 1'b0) begin
                t++;
            end
            p = dist_clk;
        end
        cmp_per(n, e);
        if (t < 2) begin
            err_total++;
            close_out();
        end
    endtask
    task cmp_out(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // ==========================================================
    // apb master; note is {pslverr, read byte}, write byte masked
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [8:0] e);
        int n;
        notes.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            cmp_rd({pslverr, pwrite ? 8'h00 : prdata[7:0]},
                   notes.pop_front());
        end
    end
    task upd;
        apb(1'b1, `CCRC_ADDR_UPD, 32'h01, 9'h000);
        // control pins land one cycle after the commit edge
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task chk(input logic [1:0] pw, input logic pl, input logic [2:0] cd,
             input logic by, input logic it);
        logic [11:0] e;
        e = {pw, pw != 2'h0, pw == 2'h0, pl, it, it, pw == 2'h0 && !it,
             by, cd + 3'h2};
        cmp_out({pll_power_mode, pll_power_down, pll_enable,
                 pfd_polarity_negative, int_osc_select, int_osc_power_on,
                 ext_to_prescaler, vco_div_bypass, vco_div_ratio}, e);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int         i;
        logic [31:0] r;
        logic [7:0] pv;
        logic [2:0] c;
        r = $urandom(99944);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CCRC_ADDR_PLL, 32'h0, 9'h001);
        apb(1'b0, `CCRC_ADDR_DIV, 32'h0, 9'h002);
        apb(1'b0, `CCRC_ADDR_ROUTE, 32'h0, 9'h000);
        chk(2'h1, 1'b0, 3'h2, 1'b0, 1'b0);
        r = $urandom;
        pv = {1'b1, r[6:2], 2'h0};
        apb(1'b1, `CCRC_ADDR_PLL, {r[31:8], pv}, 9'h000);
        apb(1'b1, `CCRC_ADDR_DIV, 32'h0, 9'h000);
        apb(1'b0, `CCRC_ADDR_PLL, 32'h0, {1'b0, pv});
        apb(1'b1, `CCRC_ADDR_UPD, 32'h02, 9'h000);
        repeat (2) @(posedge pclk);
        #1 chk(2'h1, 1'b0, 3'h2, 1'b0, 1'b0);
        upd();
        chk(2'h0, 1'b1, 3'h0, 1'b0, 1'b0);
        apb(1'b0, `CCRC_ADDR_STAT, 32'h0, 9'h080);
        r = $urandom;
        for (i = 0; i < 5; i++) begin
            c = 3'((i + r[3:0]) % 5);
            apb(1'b1, `CCRC_ADDR_DIV, {r[31:3], c}, 9'h000);
            upd();
            chk(2'h0, 1'b1, c, 1'b0, 1'b0);
            per_chk(2 * c + 4);
        end
        for (i = 5; i < 8; i++) begin
            apb(1'b1, `CCRC_ADDR_DIV, i, 9'h100);
        end
        apb(1'b0, `CCRC_ADDR_DIV, 32'h0, {6'h0, c});
        apb(1'b0, 12'h004, 32'h0, 9'h100);
        apb(1'b1, 12'h000, 32'h5, 9'h100);
        slow <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `CCRC_ADDR_ROUTE, i, 9'h000);
            apb(1'b1, `CCRC_ADDR_PLL, {pv[7:2], 2'(i)}, 9'h000);
            upd();
            chk(2'(i), 1'b1, c, i[0], i[1]);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 chk(2'h1, 1'b0, 3'h2, 1'b0, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CCRC_ADDR_PLL, 32'h0, 9'h001);
        apb(1'b0, `CCRC_ADDR_DIV, 32'h0, 9'h002);
        apb(1'b0, `CCRC_ADDR_ROUTE, 32'h0, 9'h000);
        close_out();
    end
endmodule // tb_top
